// file: core/usb_ep_pkg.sv
// Constants, field layouts and helpers shared by the endpoint controller and its FIFO memory.
// Assumes clk_sys is the 48 MHz reference that the controller is built around.
package usb_ep_pkg;

	// ==========================================================
	// Clocking
	localparam int REF_CLK_HZ    = 48_000_000;
	localparam int BIT_RATE_HZ   = 12_000_000;
	localparam int OVERSAMPLE    = REF_CLK_HZ / BIT_RATE_HZ;
	localparam logic [1:0] SAMPLE_PHASE = 2'h1;
	localparam logic [1:0] TX_LAST_PHASE = 2'(OVERSAMPLE - 1);

	// ==========================================================
	// Endpoints and FIFO memory
	localparam int NUM_EP      = 6;
	localparam int EP_W        = 3;
	localparam int PP_FIRST    = 4;
	localparam int MEM_AW      = 9;
	localparam int MEM_DEPTH   = 384;
	localparam int SMALL_DEPTH = 32;
	localparam int BIG_DEPTH   = 64;
	localparam int PP_BASE     = 128;
	localparam int PTR_W       = 7;
	localparam int CNT_W       = 10;

	// ==========================================================
	// Register fields
	localparam int CTL_EN_BIT   = 7;
	localparam int CTL_TGL_BIT  = 3;
	localparam int CTL_DIR_BIT  = 2;
	localparam int CTL_TYPE_LSB = 0;
	localparam int ST_TXCMPL    = 0;
	localparam int ST_RXOUT     = 1;
	localparam int ST_RXSETUP   = 2;
	localparam int ST_TRANSMIT_READY_BIT     = 4;
	localparam int ST_BANK      = 6;

	typedef enum logic [1:0] {
		EP_CONTROL = 2'b00,
		EP_ISO     = 2'b01,
		EP_BULK    = 2'b10,
		EP_INTR    = 2'b11
	} ep_type_t;

	// ==========================================================
	// Line protocol
	localparam logic [3:0] PID_OUT   = 4'h1;
	localparam logic [3:0] PID_IN    = 4'h9;
	localparam logic [3:0] PID_SETUP = 4'hD;
	localparam logic [3:0] PID_DATA0 = 4'h3;
	localparam logic [3:0] PID_DATA1 = 4'hB;
	localparam logic [3:0] PID_ACK   = 4'h2;
	localparam logic [3:0] PID_NAK   = 4'hA;
	localparam logic [7:0] SYNC_PATTERN   = 8'h80;
	localparam logic [4:0] CRC5_POLY      = 5'h05;
	localparam logic [4:0] CRC5_RESIDUAL  = 5'h0C;
	localparam logic [15:0] CRC16_POLY     = 16'h8005;
	localparam logic [15:0] CRC16_RESIDUAL = 16'h800D;
	localparam logic [2:0] STUFF_LIMIT    = 3'h6;
	localparam logic [3:0] EOP_SE0_BITS   = 4'h2;
	localparam logic [3:0] EOP_LAST_BIT   = 4'h3;
	localparam logic [3:0] CRC_LAST_BIT   = 4'hF;

	typedef enum logic [2:0] {
		TX_IDLE = 3'b000,
		TX_SYNC = 3'b001,
		TX_PID  = 3'b010,
		TX_DATA = 3'b011,
		TX_CRC  = 3'b100,
		TX_EOP  = 3'b101
	} tx_state_t;

	function automatic logic [MEM_AW-1:0] mem_base(input logic [EP_W-1:0] ep, input logic bank);
		if (ep < EP_W'(PP_FIRST))
			return MEM_AW'(int'(ep) * SMALL_DEPTH);
		return MEM_AW'(PP_BASE + (int'(ep) - PP_FIRST) * 2 * BIG_DEPTH + int'(bank) * BIG_DEPTH);
	endfunction

	function automatic logic [PTR_W-1:0] ep_cap(input logic [EP_W-1:0] ep);
		return (ep < EP_W'(PP_FIRST)) ? PTR_W'(SMALL_DEPTH) : PTR_W'(BIG_DEPTH);
	endfunction

endpackage

// file: core/fifo_mem_if.sv
// Two-port path between the endpoint controller and its FIFO memory.
// Port a serves firmware, port b serves the serial engine.
`timescale 1ns/1ps
interface fifo_mem_if;
	import usb_ep_pkg::*;
	logic              a_we;
	logic [MEM_AW-1:0] a_addr;
	logic [7:0]        a_wdata;
	logic [7:0]        a_rdata;
	logic              b_we;
	logic [MEM_AW-1:0] b_addr;
	logic [7:0]        b_wdata;
	logic [7:0]        b_rdata;
	modport ctl (output a_we, a_addr, a_wdata, b_we, b_addr, b_wdata, input a_rdata, b_rdata);
	modport mem (input a_we, a_addr, a_wdata, b_we, b_addr, b_wdata, output a_rdata, b_rdata);
endinterface

// file: core/ep_fifo_mem.sv
// Dual-port byte memory holding every endpoint FIFO.
// Assumes the two ports never write one address in the same cycle.
`timescale 1ns/1ps
module ep_fifo_mem import usb_ep_pkg::*; (
	input  wire logic clk_sys,
	fifo_mem_if.mem   bus
);
	// ==========================================================
	// Storage
	logic [7:0] mem_q [MEM_DEPTH];

	// Both ports share one process so the array has a single driver; port b wins a clash.
	always_ff @(posedge clk_sys) begin
		if (bus.a_we)
			mem_q[bus.a_addr] <= bus.a_wdata;
		if (bus.b_we)
			mem_q[bus.b_addr] <= bus.b_wdata;
	end

	always_ff @(posedge clk_sys) begin
		bus.a_rdata <= mem_q[bus.a_addr];
		bus.b_rdata <= mem_q[bus.b_addr];
	end
endmodule

// file: core/usb_device_endpoint_config_fifo.sv
// Full-speed device controller: serial engine, endpoint configuration and FIFO data port.
// Assumes clk_sys is the 48 MHz reference and that dp_in/dm_in are already synchronous.
`timescale 1ns/1ps
module usb_device_endpoint_config_fifo import usb_ep_pkg::*; (
	input  wire logic        clk_sys,
	input  wire logic        reset_n,
	input  wire logic [7:0]  fw_wdata,
	input  wire logic        select_we,
	input  wire logic        control_we,
	input  wire logic        status_we,
	input  wire logic        fifo_reset_we,
	input  wire logic        data_we,
	input  wire logic        data_re,
	input  wire logic        controller_enable,
	input  wire logic        function_enable,
	input  wire logic        address_enable,
	input  wire logic [6:0]  device_address,
	output logic [EP_W-1:0]  endpoint_select,
	output logic [7:0]       endpoint_status,
	output logic [7:0]       endpoint_control,
	output logic [7:0]       data_port_rdata,
	output logic [7:0]       byte_count_low,
	output logic [7:0]       byte_count_high,
	input  wire logic        dp_in,
	input  wire logic        dm_in,
	output logic             dp_out,
	output logic             dp_oe,
	output logic             dm_out,
	output logic             dm_oe
);
	// ==========================================================
	// Endpoint state
	logic [EP_W-1:0]   sel_q;
	logic [NUM_EP-1:0] en_q, dir_q, tgl_q, bank_q, txcmpl_q, rxout_q, setup_q, transmit_ready_bit_q;
	logic [NUM_EP-1:0] fifo_rst_q;
	ep_type_t          type_q   [NUM_EP];
	logic [CNT_W-1:0]  cnt_q    [NUM_EP];
	logic [PTR_W-1:0]  fwptr_q  [NUM_EP];
	logic              sel_ok;
	logic [EP_W-1:0]   sel_i;

	fifo_mem_if mem_bus ();
	ep_fifo_mem u_mem (
		.clk_sys (clk_sys),
		.bus     (mem_bus)
	);

	assign sel_ok = sel_q < EP_W'(NUM_EP);
	assign sel_i  = sel_ok ? sel_q : '0;

	// ==========================================================
	// Firmware configuration
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			sel_q      <= '0;
			fifo_rst_q <= '0;
			for (int i = 0; i < NUM_EP; i++) begin
				en_q[i]   <= (i == 0);
				dir_q[i]  <= 1'b0;
				type_q[i] <= (i >= PP_FIRST) ? EP_BULK : EP_CONTROL;
			end
		end else begin
			if (select_we)
				sel_q <= fw_wdata[EP_W-1:0];
			if (fifo_reset_we)
				fifo_rst_q <= fw_wdata[NUM_EP-1:0];
			// Endpoint zero ignores control writes so standard requests always get through.
			if (control_we && sel_ok && sel_q != '0) begin
				en_q[sel_q]  <= fw_wdata[CTL_EN_BIT];
				dir_q[sel_q] <= fw_wdata[CTL_DIR_BIT];
				if (!(sel_q >= EP_W'(PP_FIRST) && fw_wdata[CTL_TYPE_LSB +: 2] == EP_CONTROL))
					type_q[sel_q] <= ep_type_t'(fw_wdata[CTL_TYPE_LSB +: 2]);
			end
		end
	end

	// ==========================================================
	// Receiver: clock recovery, NRZI decode, unstuffing
	logic              line_prev_q, last_q, rx_act_q;
	logic [1:0]        phase_q;
	logic [2:0]        ones_q, rbit_q;
	logic [7:0]        shift_q, sh_next;
	logic [CNT_W:0]    rbytes_q;
	logic [4:0]        crc5_q;
	logic [15:0]       crc16_q;
	logic              rx_en, bit_stb, se0, dbit, stuffed, pkt_end, byte_stb;
	tx_state_t         tx_state_q;

	assign rx_en    = controller_enable && tx_state_q == TX_IDLE;
	assign bit_stb  = rx_en && phase_q == SAMPLE_PHASE;
	assign se0      = !dp_in && !dm_in;
	assign dbit     = dp_in == last_q;
	assign stuffed  = rx_act_q && ones_q == STUFF_LIMIT;
	assign sh_next  = {dbit, shift_q[7:1]};
	assign pkt_end  = bit_stb && se0 && rx_act_q;
	assign byte_stb = bit_stb && !se0 && !stuffed && rx_act_q && rbit_q == 3'h7;

	// Every dp_in edge realigns the sampling phase to mid-bit.
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			line_prev_q <= 1'b1;
			phase_q     <= '0;
		end else begin
			line_prev_q <= dp_in;
			phase_q     <= (dp_in != line_prev_q) ? 2'h0 : phase_q + 2'h1;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!reset_n || !rx_en) begin
			rx_act_q <= 1'b0;
			ones_q   <= '0;
			last_q   <= 1'b1;
			shift_q  <= '0;
			rbit_q   <= '0;
			rbytes_q <= '0;
			crc5_q   <= '1;
			crc16_q  <= '1;
		end else if (bit_stb) begin
			if (se0) begin
				rx_act_q <= 1'b0;
				ones_q   <= '0;
				last_q   <= 1'b1;
			end else begin
				last_q <= dp_in;
				if (stuffed) begin
					ones_q <= '0;
				end else begin
					ones_q  <= dbit ? ones_q + 3'h1 : 3'h0;
					shift_q <= sh_next;
					if (!rx_act_q && sh_next == SYNC_PATTERN) begin
						rx_act_q <= 1'b1;
						rbit_q   <= '0;
						rbytes_q <= '0;
						crc5_q   <= '1;
						crc16_q  <= '1;
					end else if (rx_act_q) begin
						rbit_q <= rbit_q + 3'h1;
						if (rbit_q == 3'h7)
							rbytes_q <= rbytes_q + (CNT_W+1)'(1);
						if (rbytes_q != '0) begin
							crc5_q  <= {crc5_q[3:0], 1'b0} ^ ((dbit ^ crc5_q[4]) ? CRC5_POLY : '0);
							crc16_q <= {crc16_q[14:0], 1'b0} ^ ((dbit ^ crc16_q[15]) ? CRC16_POLY : '0);
						end
					end
				end
			end
		end
	end

	// ==========================================================
	// Packet decode and transaction control
	logic [7:0]       pid_q, b1_q, b2_q;
	logic [3:0]       pid, tok_pid_q, tx_pid_q;
	logic [EP_W-1:0]  tok_ep_q, tok_ep;
	logic [PTR_W-1:0] rx_ptr_q, tx_ptr_q;
	logic             tok_ok_q, accept_q, await_ack_q, tx_req_q, tx_data_q;
	logic             pid_good, is_token, tok_hit, data_end, tok_iso, tok_ctrl, tx_fin;
	logic             setup_done, out_done, in_done, tgl_match, dp_ctrl, new_ctrl;
	logic [6:0]       my_addr;
	logic [CNT_W-1:0] data_cnt;

	assign pid      = pid_q[3:0];
	assign pid_good = pid_q[7:4] == ~pid_q[3:0];
	assign is_token = pid == PID_OUT || pid == PID_IN || pid == PID_SETUP;
	assign tok_ep   = {b2_q[1:0], b1_q[7]};
	assign my_addr  = address_enable ? device_address : 7'h00;
	assign new_ctrl = type_q[tok_ep] == EP_CONTROL;
	assign tok_hit  = pkt_end && pid_good && is_token && rbytes_q == (CNT_W+1)'(3)
		&& crc5_q == CRC5_RESIDUAL && function_enable && b1_q[6:0] == my_addr
		&& !b2_q[2] && tok_ep < EP_W'(NUM_EP) && en_q[tok_ep];
	assign tok_iso   = type_q[tok_ep_q] == EP_ISO;
	assign tok_ctrl  = type_q[tok_ep_q] == EP_CONTROL;
	assign data_end  = pkt_end && pid_good && (pid == PID_DATA0 || pid == PID_DATA1)
		&& rbytes_q >= (CNT_W+1)'(3) && crc16_q == CRC16_RESIDUAL && tok_ok_q && tok_pid_q != PID_IN;
	assign data_cnt  = CNT_W'(rbytes_q - (CNT_W+1)'(3));
	assign tgl_match = (pid == PID_DATA1) == tgl_q[tok_ep_q];
	assign setup_done = data_end && tok_pid_q == PID_SETUP && accept_q;
	assign out_done   = data_end && tok_pid_q == PID_OUT && accept_q && (tok_iso || tgl_match);
	assign in_done    = (pkt_end && pid_good && pid == PID_ACK && await_ack_q)
		|| (tx_fin && tx_data_q && tok_iso);
	assign dp_ctrl    = pid_q[3:0] == PID_DATA0 || pid_q[3:0] == PID_DATA1;

	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			pid_q <= '0; b1_q <= '0; b2_q <= '0;
			tok_pid_q <= '0; tok_ep_q <= '0; tok_ok_q <= 1'b0; accept_q <= 1'b0;
			await_ack_q <= 1'b0; tx_req_q <= 1'b0; tx_data_q <= 1'b0; tx_pid_q <= '0;
			rx_ptr_q <= '0;
		end else begin
			tx_req_q <= 1'b0;
			if (byte_stb) begin
				if (rbytes_q == '0) begin
					pid_q    <= sh_next;
					rx_ptr_q <= '0;
				end else if (mem_bus.b_we) begin
					rx_ptr_q <= rx_ptr_q + PTR_W'(1);
				end
				if (rbytes_q == (CNT_W+1)'(1))
					b1_q <= sh_next;
				if (rbytes_q == (CNT_W+1)'(2))
					b2_q <= sh_next;
			end
			if (pkt_end)
				await_ack_q <= 1'b0;
			if (pkt_end && pid_good && is_token) begin
				tok_ok_q  <= tok_hit;
				tok_pid_q <= pid;
				if (tok_hit) begin
					tok_ep_q <= tok_ep;
					accept_q <= (pid == PID_SETUP) ? new_ctrl
						: (pid == PID_OUT && !rxout_q[tok_ep] && (new_ctrl || !dir_q[tok_ep]));
					if (pid == PID_IN) begin
						if (transmit_ready_bit_q[tok_ep] && (new_ctrl || dir_q[tok_ep])) begin
							tx_req_q  <= 1'b1;
							tx_data_q <= 1'b1;
							tx_pid_q  <= tgl_q[tok_ep] ? PID_DATA1 : PID_DATA0;
						end else if (type_q[tok_ep] != EP_ISO) begin
							tx_req_q  <= 1'b1;
							tx_data_q <= 1'b0;
							tx_pid_q  <= PID_NAK;
						end
					end
				end
			end
			if (data_end) begin
				tok_ok_q <= 1'b0;
				if (!tok_iso || tok_pid_q == PID_SETUP) begin
					tx_req_q  <= 1'b1;
					tx_data_q <= 1'b0;
					tx_pid_q  <= accept_q ? PID_ACK : PID_NAK;
				end
			end
			if (tx_fin && tx_data_q && !tok_iso)
				await_ack_q <= 1'b1;
		end
	end

	// ==========================================================
	// Per-endpoint flags, toggle and bank
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			{tgl_q, bank_q, txcmpl_q, rxout_q, setup_q, transmit_ready_bit_q} <= '0;
		end else begin
			for (int i = 0; i < NUM_EP; i++) begin
				if (status_we && sel_q == EP_W'(i)) begin
					if (!fw_wdata[ST_TXCMPL])
						txcmpl_q[i] <= 1'b0;
					if (!fw_wdata[ST_RXOUT]) begin
						rxout_q[i] <= 1'b0;
						if (rxout_q[i] && i >= PP_FIRST)
							bank_q[i] <= ~bank_q[i];
					end
					if (!fw_wdata[ST_RXSETUP])
						setup_q[i] <= 1'b0;
					transmit_ready_bit_q[i] <= fw_wdata[ST_TRANSMIT_READY_BIT];
				end
				// Bank is left alone here on purpose.
				if (fifo_rst_q[i])
					tgl_q[i] <= 1'b0;
				// Hardware events come last so they beat a same-cycle firmware write or FIFO reset.
				if (tok_ep_q == EP_W'(i)) begin
					if (setup_done) begin
						setup_q[i] <= 1'b1;
						tgl_q[i]   <= 1'b1;
					end
					if (out_done) begin
						rxout_q[i] <= 1'b1;
						tgl_q[i]   <= ~tgl_q[i];
					end
					if (in_done) begin
						transmit_ready_bit_q[i]  <= 1'b0;
						txcmpl_q[i] <= 1'b1;
						tgl_q[i]    <= ~tgl_q[i];
						if (i >= PP_FIRST)
							bank_q[i] <= ~bank_q[i];
					end
				end
			end
		end
	end

	// ==========================================================
	// Byte counters and firmware FIFO pointers
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			for (int i = 0; i < NUM_EP; i++) begin
				cnt_q[i]   <= '0;
				fwptr_q[i] <= '0;
			end
		end else begin
			for (int i = 0; i < NUM_EP; i++) begin
				if (fifo_rst_q[i])
					cnt_q[i] <= '0;
				else if (tok_ep_q == EP_W'(i) && (setup_done || out_done))
					cnt_q[i] <= data_cnt;
				if (fifo_rst_q[i] || (in_done && tok_ep_q == EP_W'(i))
					|| (status_we && sel_q == EP_W'(i)
					&& ((rxout_q[i] && !fw_wdata[ST_RXOUT]) || (setup_q[i] && !fw_wdata[ST_RXSETUP])
					|| (transmit_ready_bit_q[i] && !fw_wdata[ST_TRANSMIT_READY_BIT]))))
					fwptr_q[i] <= '0;
				else if (sel_q == EP_W'(i) && (data_we || data_re) && fwptr_q[i] < ep_cap(EP_W'(i)))
					fwptr_q[i] <= fwptr_q[i] + PTR_W'(1);
			end
		end
	end

	// ==========================================================
	// FIFO memory ports
	always_comb begin
		mem_bus.a_addr  = mem_base(sel_i, bank_q[sel_i]) + MEM_AW'(fwptr_q[sel_i]);
		mem_bus.a_we    = data_we && sel_ok && fwptr_q[sel_i] < ep_cap(sel_i);
		mem_bus.a_wdata = fw_wdata;
		mem_bus.b_addr  = mem_base(tok_ep_q, bank_q[tok_ep_q])
			+ MEM_AW'((tx_state_q != TX_IDLE) ? tx_ptr_q : rx_ptr_q);
		// Overflow bytes are counted but never stored.
		mem_bus.b_we    = byte_stb && rbytes_q != '0 && dp_ctrl && accept_q
			&& rx_ptr_q < ep_cap(tok_ep_q);
		mem_bus.b_wdata = sh_next;
	end

	// ==========================================================
	// Transmitter: sync, PID, data, CRC, end of packet
	logic [1:0]  tx_div_q;
	logic [3:0]  tbit_q;
	logic [2:0]  tones_q;
	logic [7:0]  tsh_q;
	logic [15:0] tcrc_q;
	logic        line_q, se0_q, tx_stb, tbit;

	assign tx_stb = tx_state_q != TX_IDLE && tx_div_q == TX_LAST_PHASE;
	assign tbit   = (tx_state_q == TX_CRC) ? ~tcrc_q[15] : tsh_q[0];
	assign tx_fin = tx_stb && tx_state_q == TX_EOP && tbit_q == EOP_LAST_BIT;

	always_ff @(posedge clk_sys) begin
		if (!reset_n || !controller_enable) begin
			tx_state_q <= TX_IDLE;
			tx_div_q <= '0; tbit_q <= '0; tones_q <= '0; tsh_q <= '0;
			tcrc_q <= '1; line_q <= 1'b1; se0_q <= 1'b0; tx_ptr_q <= '0;
		end else if (tx_req_q) begin
			tx_state_q <= TX_SYNC;
			tx_div_q <= '0; tbit_q <= '0; tones_q <= '0;
			tsh_q <= SYNC_PATTERN; tcrc_q <= '1; line_q <= 1'b1; tx_ptr_q <= '0;
		end else if (tx_state_q != TX_IDLE) begin
			tx_div_q <= tx_div_q + 2'h1;
			if (tx_stb) begin
				if (tones_q == STUFF_LIMIT) begin
					line_q  <= ~line_q;
					tones_q <= '0;
				end else begin
					case (tx_state_q)
						TX_EOP: begin
							se0_q  <= tbit_q < EOP_SE0_BITS;
							line_q <= 1'b1;
							tbit_q <= tbit_q + 4'h1;
							if (tx_fin) begin
								tx_state_q <= TX_IDLE;
								se0_q      <= 1'b0;
							end
						end
						default: begin
							line_q  <= tbit ? line_q : ~line_q;
							tones_q <= tbit ? tones_q + 3'h1 : 3'h0;
							tsh_q   <= {1'b0, tsh_q[7:1]};
							tbit_q  <= tbit_q + 4'h1;
							if (tx_state_q == TX_DATA)
								tcrc_q <= {tcrc_q[14:0], 1'b0} ^ ((tbit ^ tcrc_q[15]) ? CRC16_POLY : '0);
							if (tx_state_q == TX_CRC)
								tcrc_q <= {tcrc_q[14:0], 1'b1};
							if (tbit_q[2:0] == 3'h7 && tx_state_q != TX_CRC) begin
								tbit_q <= '0;
								case (tx_state_q)
									TX_SYNC: begin
										tx_state_q <= TX_PID;
										tsh_q      <= {~tx_pid_q, tx_pid_q};
									end
									default: begin
										if (!tx_data_q) begin
											tx_state_q <= TX_EOP;
										end else if (tx_ptr_q == fwptr_q[tok_ep_q]) begin
											tx_state_q <= TX_CRC;
										end else begin
											tx_state_q <= TX_DATA;
											tsh_q      <= mem_bus.b_rdata;
											tx_ptr_q   <= tx_ptr_q + PTR_W'(1);
										end
									end
								endcase
							end
							if (tx_state_q == TX_CRC && tbit_q == CRC_LAST_BIT) begin
								tbit_q     <= '0;
								tx_state_q <= TX_EOP;
							end
						end
					endcase
				end
			end
		end
	end

	assign dp_out = !se0_q && line_q;
	assign dm_out = !se0_q && !line_q;
	assign dp_oe  = tx_state_q != TX_IDLE;
	assign dm_oe  = tx_state_q != TX_IDLE;

	// ==========================================================
	// Register readout for the selected endpoint
	assign data_port_rdata = mem_bus.a_rdata;
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			endpoint_select  <= '0;
			endpoint_status  <= '0;
			endpoint_control <= '0;
			byte_count_low   <= '0;
			byte_count_high  <= '0;
		end else begin
			endpoint_select  <= sel_q;
			endpoint_status  <= '0;
			endpoint_control <= '0;
			byte_count_low   <= '0;
			byte_count_high  <= '0;
			if (sel_ok) begin
				endpoint_status[ST_TXCMPL]  <= txcmpl_q[sel_q];
				endpoint_status[ST_RXOUT]   <= rxout_q[sel_q];
				endpoint_status[ST_RXSETUP] <= setup_q[sel_q];
				endpoint_status[ST_TRANSMIT_READY_BIT]   <= transmit_ready_bit_q[sel_q];
				endpoint_status[ST_BANK]    <= bank_q[sel_q];
				endpoint_control[CTL_EN_BIT]  <= en_q[sel_q];
				endpoint_control[CTL_TGL_BIT] <= tgl_q[sel_q];
				endpoint_control[CTL_DIR_BIT] <= dir_q[sel_q];
				endpoint_control[CTL_TYPE_LSB +: 2] <= type_q[sel_q];
				byte_count_low  <= cnt_q[sel_q][7:0];
				byte_count_high <= 8'(cnt_q[sel_q][CNT_W-1:8]);
			end
		end
	end
endmodule

// file: verification/usb_ep_properties.sv
// Checker for the endpoint controller, watching only its top ports.
// Assumes the bind in the bench top file.
`timescale 1ns/1ps
module usb_ep_properties import usb_ep_pkg::*; (
	input wire logic            clk_sys,
	input wire logic            reset_n,
	input wire logic [7:0]      fw_wdata,
	input wire logic            select_we,
	input wire logic            control_we,
	input wire logic            fifo_reset_we,
	input wire logic            data_we,
	input wire logic            data_re,
	input wire logic            controller_enable,
	input wire logic [EP_W-1:0] endpoint_select,
	input wire logic [7:0]      endpoint_control,
	input wire logic [7:0]      byte_count_low,
	input wire logic [7:0]      byte_count_high,
	input wire logic            dp_oe,
	input wire logic            dm_oe
);
	// ==========================================================
	// Assertions
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!reset_n);
	property p_sel; logic [2:0] v;
		(select_we, v = fw_wdata[2:0]) |-> ##2 endpoint_select == v; endproperty
	a_sel: assert property (p_sel) else $error("select not followed");
	property p_quiet; (!controller_enable) [*3] |-> !dp_oe && !dm_oe; endproperty
	a_quiet: assert property (p_quiet) else $error("bus driven while off");
	property p_ep0;
		(endpoint_select == 3'h0) [*3] |-> endpoint_control[7] && endpoint_control[1:0] == 2'h0;
	endproperty
	a_ep0: assert property (p_ep0) else $error("endpoint zero not control");
	property p_pp; logic [1:0] t;
		(control_we && endpoint_select inside {3'h4, 3'h5} && fw_wdata[1:0] == 2'h0,
			t = endpoint_control[1:0]) |-> ##2 endpoint_control[1:0] == t; endproperty
	a_pp: assert property (p_pp) else $error("ping-pong took control type");
	property p_fields; logic [7:0] v;
		(control_we && endpoint_select inside {[3'h1:3'h3]}, v = fw_wdata) |-> ##2
			endpoint_control[7] == v[7] && endpoint_control[2:0] == v[2:0]; endproperty
	a_fields: assert property (p_fields) else $error("control fields wrong");
	property p_frst; fifo_reset_we && endpoint_select < 3'h6 && fw_wdata[endpoint_select]
		|-> ##3 {byte_count_high, byte_count_low} == 16'h0 && !endpoint_control[3]; endproperty
	a_frst: assert property (p_frst) else $error("fifo reset incomplete");
	property p_wcnt; data_we |=> $stable({byte_count_high, byte_count_low}) [*2]; endproperty
	a_wcnt: assert property (p_wcnt) else $error("count moved on write");
	property p_rcnt; data_re |=> $stable({byte_count_high, byte_count_low}) [*2]; endproperty
	a_rcnt: assert property (p_rcnt) else $error("count moved on read");
endmodule

// file: verification/usb_host_model.sv
// Host on the far side of the bus: idles in J, can send a corrupt packet.
// Assumes the bench resolves the pins from the device's output enables alone.
`timescale 1ns/1ps
module usb_host_model (
	input  wire logic clk_sys,
	input  wire logic dev_oe,
	output logic      dp,
	output logic      dm,
	output int        n_answers
);
	// ==========================================================
	// Line driving
	logic oe_q = 1'b0;
	initial begin
		dp = 1'b1;
		dm = 1'b0;
		n_answers = 0;
	end
	// One line state per bit time of four clocks.
	task automatic put(input logic p, input logic m);
		dp = p;
		dm = m;
		repeat (4) @(posedge clk_sys);
		#1;
	endtask
	// Broken framing, so a correct device must stay silent.
	task automatic send_junk();
		for (int i = 0; i < 8; i++)
			put(i[0], !i[0]);
		put(1'b0, 1'b0);
		put(1'b0, 1'b0);
		put(1'b1, 1'b0);
	endtask
	// Sync, then three bytes LSB first in NRZI; callers pick bytes that need no stuffing.
	task automatic send_token(input logic [23:0] pkt);
		logic j;
		j = 1'b1;
		for (int i = 0; i < 32; i++) begin
			if (!((i < 8) ? (i == 7) : pkt[i - 8]))
				j = !j;
			put(j, !j);
		end
		put(1'b0, 1'b0);
		put(1'b0, 1'b0);
		put(1'b1, 1'b0);
	endtask
	always @(posedge clk_sys) begin
		oe_q <= dev_oe;
		if (dev_oe && !oe_q)
			n_answers <= n_answers + 1;
	end
endmodule

// file: verification/tb_usb_device_endpoint_config_fifo.sv
// Self-checking bench: firmware strobe tasks and a host model on the pins.
// Assumes the checker and host model files are compiled first.
`timescale 1ns/1ps
module tb_usb_device_endpoint_config_fifo;
	import usb_ep_pkg::*;
	// ==========================================================
	// Signals and instances
	logic clk_sys, reset_n, controller_enable, function_enable, h_dp, h_dm, dp_out, dp_oe;
	logic dm_out, dm_oe;
	logic [5:0]      we;
	logic [7:0]      fw_wdata, status, control, rdata, cnt_lo, cnt_hi;
	logic [EP_W-1:0] sel;
	int              n_errors = 0, checked = 0, cycles = 0, n_answers;
	logic [7:0]      types [4] = '{8'h80, 8'h81, 8'h86, 8'h87};
	usb_device_endpoint_config_fifo i_usb_device_endpoint_config_fifo (.clk_sys, .reset_n,
		.fw_wdata, .select_we(we[0]), .control_we(we[1]), .status_we(we[2]),
		.fifo_reset_we(we[3]), .data_we(we[4]), .data_re(we[5]), .controller_enable,
		.function_enable, .address_enable(1'b0), .device_address(7'h00),
		.endpoint_select(sel), .endpoint_status(status), .endpoint_control(control),
		.data_port_rdata(rdata), .byte_count_low(cnt_lo), .byte_count_high(cnt_hi),
		.dp_in(dp_oe ? dp_out : h_dp), .dm_in(dm_oe ? dm_out : h_dm),
		.dp_out, .dp_oe, .dm_out, .dm_oe);
	usb_host_model i_usb_host_model (.clk_sys, .dev_oe(dp_oe), .dp(h_dp), .dm(h_dm), .n_answers);
	// ==========================================================
	// Tasks
	// Strobe k is high for one cycle, then the readouts get time to settle.
	task automatic wr(input int k, input logic [7:0] d);
		@(posedge clk_sys);
		#1;
		fw_wdata = d;
		we = 6'h01 << k;
		@(posedge clk_sys);
		#1;
		we = 6'h00;
		repeat (3) @(posedge clk_sys);
		#1;
	endtask
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp) begin
			n_errors++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic report_and_stop();
		$display("checks %0d errors %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// ==========================================================
	// Clock, timeout and tests
	initial begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 3000) begin
			n_errors++;
			report_and_stop();
		end
	end
	initial begin
		reset_n = 1'b0;
		controller_enable = 1'b0;
		function_enable = 1'b0;
		we = 6'h00;
		fw_wdata = 8'h00;
		repeat (4) @(posedge clk_sys);
		#1;
		reset_n = 1'b1;
		wr(0, 8'h00);
		wr(1, 8'h86);
		check(control, 8'h80);
		wr(0, 8'h01);
		foreach (types[i]) begin
			wr(1, types[i]);
			check(control & 8'hF7, types[i]);
		end
		wr(0, 8'h04);
		wr(1, 8'h82);
		wr(1, 8'h80);
		check(control & 8'hF7, 8'h82);
		wr(0, 8'h01);
		wr(3, 8'h02);
		wr(3, 8'h00);
		foreach (types[i])
			wr(4, types[i]);
		check({cnt_hi, cnt_lo}, 16'h0000);
		wr(3, 8'h02);
		wr(3, 8'h00);
		check(rdata, 8'h80);
		wr(5, 8'h00);
		check(rdata, 8'h81);
		wr(3, 8'h04);
		wr(3, 8'h00);
		check(rdata, 8'h81);
		i_usb_host_model.send_token(24'h100069);
		repeat (20) @(posedge clk_sys);
		#1;
		check(16'(n_answers), 16'h0000);
		controller_enable = 1'b1;
		i_usb_host_model.send_junk();
		i_usb_host_model.send_token(24'h180069);
		i_usb_host_model.send_token(24'h100069);
		repeat (20) @(posedge clk_sys);
		#1;
		check(16'(n_answers), 16'h0000);
		function_enable = 1'b1;
		i_usb_host_model.send_token(24'h100069);
		repeat (20) @(posedge clk_sys);
		#1;
		check(16'(n_answers), 16'h0001);
		report_and_stop();
	end
endmodule
bind usb_device_endpoint_config_fifo usb_ep_properties i_usb_ep_properties (.clk_sys, .reset_n,
	.fw_wdata, .select_we, .control_we, .fifo_reset_we, .data_we, .data_re, .controller_enable,
	.endpoint_select, .endpoint_control, .byte_count_low, .byte_count_high, .dp_oe, .dm_oe);
